//--- src/sav_map.svh
// register map, timing figures and field layout of the safeguard voting block
`ifndef SAV_MAP_SVH
`define SAV_MAP_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one word each)
// ----------------------------------------------------------------
`define SAV_ADDR_W    4
`define SAV_REG_CTRL  4'h0
`define SAV_REG_STAT  4'h4

// ----------------------------------------------------------------
// control and status fields
// ----------------------------------------------------------------
`define SAV_DLY_W     11
`define SAV_DLY_LSB   0
`define SAV_STAT_W    16

// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define SAV_CLK_NS     5
`define SAV_MS_NS      1000000
`define SAV_DLY_MAX_S  2
`define SAV_DLY_MAX_MS (`SAV_DLY_MAX_S * 1000)

// ----------------------------------------------------------------
// vote thresholds
// ----------------------------------------------------------------
`define SAV_K_OF_FOUR  2
`define SAV_K_OF_THREE 2

`endif

//--- src/sav_pkg.sv
// types shared by the safeguard voting block
package sav_pkg;
	// actuation delay sequencer
	typedef enum logic [1:0] {
		SAV_IDLE,
		SAV_TIMING,
		SAV_FIRED
	} sav_dly_st_t;
endpackage

//--- src/sav_vote.sv
// k-out-of-n coincidence voter
`timescale 1ns/100ps
module sav_vote #(
	parameter int N = 4,
	parameter int K = 2
) (
	input  wire logic [N-1:0] trip,
	output logic              hit
);
	// count tripped channels and compare with the threshold
	always_comb begin
		int cnt;
		cnt = 0;
		for (int i = 0; i < N; i++) begin
			cnt = cnt + int'(trip[i]);
		end
		hit = (cnt >= K);
	end
endmodule

//--- src/sav_top.sv
// safeguard actuation voting, latching and delay logic with avalon register access
//
// The implementer's own choices: the register addresses and register access over Avalon-MM.
`timescale 1ns/100ps
`include "sav_map.svh"
module sav_top #(
	parameter int FW         = 12,
	parameter int CYC_PER_MS = `SAV_MS_NS / `SAV_CLK_NS
) (
	input  wire logic                   sys_clk,
	input  wire logic                   rst,
	input  wire logic [`SAV_ADDR_W-1:0] avs_address,
	input  wire logic                   avs_read,
	input  wire logic                   avs_write,
	input  wire logic [31:0]            avs_writedata,
	output logic      [31:0]            avs_readdata,
	output logic                        avs_waitrequest,
	input  wire logic [4*FW-1:0]        flow_a,
	input  wire logic [4*FW-1:0]        flow_b,
	input  wire logic [FW-1:0]          flow_ref_a,
	input  wire logic [FW-1:0]          flow_ref_b,
	input  wire logic [3:0]             avg_coolant_temp_low,
	input  wire logic [3:0]             steam_press_low,
	input  wire logic                   avg_coolant_temp_perm,
	input  wire logic                   steam_press_perm,
	input  wire logic [2:0]             cont_hi_trip,
	input  wire logic [11:0]            cont_hihi_trip,
	input  wire logic [1:0]             man_si,
	input  wire logic [1:0]             si_reset,
	input  wire logic [1:0]             si_defeat,
	input  wire logic                   man_pha,
	input  wire logic                   man_phb,
	input  wire logic                   man_spray,
	input  wire logic                   pha_reset,
	input  wire logic                   phb_reset,
	input  wire logic                   spray_reset,
	input  wire logic                   msiv_reset,
	input  wire logic [1:0]             vent_reset,
	input  wire logic                   pha_bypass,
	input  wire logic                   vent_b_bypass,
	output logic      [1:0]             si_out,
	output logic                        reactor_trip,
	output logic                        msiv_close,
	output logic                        spray_out,
	output logic                        pha_out,
	output logic                        phb_out,
	output logic      [1:0]             vent_iso,
	output logic      [1:0]             defeat_lamp,
	output logic                        control_room_alarm
);
	localparam int SW = 42;
	localparam int PW = $clog2(CYC_PER_MS);

	// ----------------------------------------------------------------
	// declarations
	// ----------------------------------------------------------------
	logic [SW-1:0]           raw;
	logic [SW-1:0]           s1_q;
	logic [SW-1:0]           s2_q;
	logic [3:0]              temp_s;
	logic [3:0]              press_s;
	logic                    tperm_s;
	logic                    pperm_s;
	logic [2:0]              chi_s;
	logic [11:0]             chh_s;
	logic [1:0]              man_si_s;
	logic [1:0]              si_rst_s;
	logic [1:0]              si_dft_s;
	logic                    man_pha_s;
	logic                    man_phb_s;
	logic                    man_spray_s;
	logic                    pha_rst_s;
	logic                    phb_rst_s;
	logic                    spray_rst_s;
	logic                    msiv_rst_s;
	logic [1:0]              vent_rst_s;
	logic                    pha_byp_s;
	logic                    vent_byp_s;
	logic [3:0]              trip_a;
	logic [3:0]              trip_b;
	logic [3:0]              ln_hi_q;
	logic                    brk;
	logic                    temp_v;
	logic                    press_v;
	logic                    chi_v;
	logic [3:0]              hh_v;
	logic [1:0]              hh_conf;
	logic                    ilk;
	sav_pkg::sav_dly_st_t    dly_st_q;
	logic [PW-1:0]           pre_q;
	logic [`SAV_DLY_W-1:0]   ms_q;
	logic [`SAV_DLY_W-1:0]   dly_q;
	logic                    fire;
	logic [1:0]              si_auto;
	logic [1:0]              si_q;
	logic [1:0]              blk_q;
	logic                    rtrip_q;
	logic                    msiv_q;
	logic                    msiv_auto;
	logic                    pha_q;
	logic                    pha_auto;
	logic                    phb_q;
	logic                    spray_q;
	logic [1:0]              vent_q;
	logic [1:0]              lamp_q;
	logic                    alarm_q;
	logic                    wait_q;
	logic [31:0]             rdata_q;
	logic [`SAV_STAT_W-1:0]  stat;

	// next value of a plain actuation latch: any cause sets, reset only when causes gone
	function automatic logic latch_d(input logic q, input logic man, input logic auto,
			input logic clr);
		latch_d = man | auto | (q & ~clr);
	endfunction

	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	assign raw = {avg_coolant_temp_low, steam_press_low, avg_coolant_temp_perm,
		steam_press_perm, cont_hi_trip, cont_hihi_trip, man_si, si_reset, si_defeat,
		man_pha, man_phb, man_spray, pha_reset, phb_reset, spray_reset, msiv_reset,
		vent_reset, pha_bypass, vent_b_bypass};

	// two flops on every plant and operator pin except the flow words (not the avalon bus) before any vote sees it
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			s1_q <= '0;
			s2_q <= '0;
		end else begin
			s1_q <= raw;
			s2_q <= s1_q;
		end
	end

	assign {temp_s, press_s, tperm_s, pperm_s, chi_s, chh_s, man_si_s, si_rst_s,
		si_dft_s, man_pha_s, man_phb_s, man_spray_s, pha_rst_s, phb_rst_s, spray_rst_s,
		msiv_rst_s, vent_rst_s, pha_byp_s, vent_byp_s} = s2_q;

	// ----------------------------------------------------------------
	// steam flow comparison and voting
	// ----------------------------------------------------------------
	// flow words come from same-clock conditioning logic, so no synchroniser
	for (genvar g = 0; g < 4; g++) begin : g_line
		assign trip_a[g] = flow_a[g*FW +: FW] > flow_ref_a;
		assign trip_b[g] = flow_b[g*FW +: FW] > flow_ref_b;
	end

	// one-out-of-two per line
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ln_hi_q <= '0;
		end else begin
			ln_hi_q <= trip_a | trip_b;
		end
	end

	sav_vote #(.N(4), .K(`SAV_K_OF_FOUR)) u_brk (.trip(ln_hi_q), .hit(brk));
	sav_vote #(.N(4), .K(`SAV_K_OF_FOUR)) u_temp (.trip(temp_s), .hit(temp_v));
	sav_vote #(.N(4), .K(`SAV_K_OF_FOUR)) u_press (.trip(press_s), .hit(press_v));
	sav_vote #(.N(3), .K(`SAV_K_OF_THREE)) u_chi (.trip(chi_s), .hit(chi_v));

	// four 2/3 relay sets: sets 0,1 form train A, sets 2,3 train B
	for (genvar g = 0; g < 4; g++) begin : g_hh
		sav_vote #(.N(3), .K(`SAV_K_OF_THREE)) u_hh (
			.trip(chh_s[g*3 +: 3]),
			.hit (hh_v[g])
		);
	end
	assign hh_conf = {hh_v[3] & hh_v[2], hh_v[1] & hh_v[0]};

	// break plus low vote, blocked above both permissives
	assign ilk = brk & (temp_v | press_v) & ~(tperm_s & pperm_s);

	// ----------------------------------------------------------------
	// actuation delay
	// ----------------------------------------------------------------
	// delay in whole milliseconds; the condition must persist through it or we start over
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dly_st_q <= sav_pkg::SAV_IDLE;
			pre_q    <= '0;
			ms_q     <= '0;
		end else begin
			unique case (dly_st_q)
				sav_pkg::SAV_IDLE: begin
					pre_q <= '0;
					ms_q  <= '0;
					if (ilk) begin
						dly_st_q <= (dly_q == '0) ? sav_pkg::SAV_FIRED : sav_pkg::SAV_TIMING;
					end
				end
				sav_pkg::SAV_TIMING: begin
					if (!ilk) begin
						dly_st_q <= sav_pkg::SAV_IDLE;
					end else if (ms_q >= dly_q) begin
						dly_st_q <= sav_pkg::SAV_FIRED;
					end else if (pre_q == PW'(CYC_PER_MS - 1)) begin
						pre_q <= '0;
						ms_q  <= ms_q + 1'b1;
					end else begin
						pre_q <= pre_q + 1'b1;
					end
				end
				sav_pkg::SAV_FIRED: begin
					if (!ilk) begin
						dly_st_q <= sav_pkg::SAV_IDLE;
					end
				end
				default: begin
					dly_st_q <= sav_pkg::SAV_IDLE;
				end
			endcase
		end
	end
	assign fire = (dly_st_q == sav_pkg::SAV_FIRED);

	// ----------------------------------------------------------------
	// safety injection trains
	// ----------------------------------------------------------------
	assign si_auto = {2{fire | chi_v}} | hh_conf;

	// manual first, then reset, then automatic set; block stops re-arming after defeat
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			si_q  <= '0;
			blk_q <= '0;
		end else begin
			for (int t = 0; t < 2; t++) begin
				if (man_si_s[t]) begin
					si_q[t]  <= 1'b1;
					blk_q[t] <= 1'b0;
				end else if (si_rst_s[t] && (!si_auto[t] || si_dft_s[t])) begin
					si_q[t]  <= 1'b0;
					blk_q[t] <= si_auto[t];
				end else begin
					si_q[t]  <= si_q[t] | (si_auto[t] & ~blk_q[t]);
					blk_q[t] <= blk_q[t] & si_auto[t] & si_dft_s[t];
				end
			end
		end
	end

	// reactor trip follows either manual injection button
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			rtrip_q <= 1'b0;
		end else begin
			rtrip_q <= |man_si_s;
		end
	end

	// defeat indication
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			lamp_q  <= '0;
			alarm_q <= 1'b0;
		end else begin
			lamp_q  <= si_dft_s;
			alarm_q <= |si_dft_s;
		end
	end

	// ----------------------------------------------------------------
	// isolation and spray latches
	// ----------------------------------------------------------------
	assign msiv_auto = fire | (|hh_conf);
	assign pha_auto  = |si_auto;

	// no defeat for these: reset only clears once every cause is gone
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			msiv_q  <= 1'b0;
			pha_q   <= 1'b0;
			phb_q   <= 1'b0;
			spray_q <= 1'b0;
			vent_q  <= '0;
		end else begin
			msiv_q  <= latch_d(msiv_q, 1'b0, msiv_auto, msiv_rst_s);
			pha_q   <= latch_d(pha_q, man_pha_s, pha_auto, pha_rst_s | pha_byp_s);
			phb_q   <= latch_d(phb_q, man_phb_s, |hh_conf, phb_rst_s);
			spray_q <= latch_d(spray_q, man_spray_s, |hh_conf, spray_rst_s);
			vent_q[0] <= latch_d(vent_q[0], 1'b0, hh_conf[0], vent_rst_s[0]);
			vent_q[1] <= latch_d(vent_q[1], 1'b0, hh_conf[1], vent_rst_s[1] | vent_byp_s);
		end
	end

	// ----------------------------------------------------------------
	// avalon slave: one wait cycle per access
	// ----------------------------------------------------------------
	assign stat = {4'h0, fire, brk, alarm_q, rtrip_q, vent_q, phb_q, pha_q, spray_q,
		msiv_q, si_q};

	// waitrequest drops for one cycle; write lands on the edge the master sees it low
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_q  <= 1'b1;
			rdata_q <= 32'h0000_0000;
		end else begin
			wait_q <= ~((avs_read | avs_write) & wait_q);
			if (avs_read && wait_q) begin
				unique case (avs_address)
					`SAV_REG_CTRL: rdata_q <= 32'(dly_q);
					`SAV_REG_STAT: rdata_q <= 32'(stat);
					default:       rdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end

	// delay setting; out-of-range values clamp to the two second ceiling
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			dly_q <= `SAV_DLY_W'(`SAV_DLY_MAX_MS);
		end else if (avs_write && !wait_q && avs_address == `SAV_REG_CTRL) begin
			if (avs_writedata > 32'(`SAV_DLY_MAX_MS)) begin
				dly_q <= `SAV_DLY_W'(`SAV_DLY_MAX_MS);
			end else begin
				dly_q <= avs_writedata[`SAV_DLY_LSB +: `SAV_DLY_W];
			end
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign avs_readdata       = rdata_q;
	assign avs_waitrequest    = wait_q;
	assign si_out             = si_q;
	assign reactor_trip       = rtrip_q;
	assign msiv_close         = msiv_q;
	assign spray_out          = spray_q;
	assign pha_out            = pha_q;
	assign phb_out            = phb_q;
	assign vent_iso           = vent_q;
	assign defeat_lamp        = lamp_q;
	assign control_room_alarm = alarm_q;

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	property p_flow_line;
		(flow_a[FW-1:0] > flow_ref_a) |=> ln_hi_q[0];
	endproperty
	a_flow_line: assert property (p_flow_line) else $error("line 0 high flow missed");

	property p_break_vote;
		(flow_a[FW-1:0] > flow_ref_a) && (flow_b[2*FW-1:FW] > flow_ref_b) |=> brk;
	endproperty
	a_break_vote: assert property (p_break_vote) else $error("2/4 break vote wrong");

	property p_dly_drop;
		!ilk |=> dly_st_q == sav_pkg::SAV_IDLE;
	endproperty
	a_dly_drop: assert property (p_dly_drop) else $error("delay kept without cause");

	property p_dly_zero;
		(dly_q == '0) && ilk && dly_st_q == sav_pkg::SAV_IDLE |=> fire ##1 msiv_q;
	endproperty
	a_dly_zero: assert property (p_dly_zero) else $error("zero delay not immediate");

	property p_cont_si;
		chi_v && !man_si_s[0] && !si_rst_s[0] && !blk_q[0] |=> si_q[0];
	endproperty
	a_cont_si: assert property (p_cont_si) else $error("high pressure no injection");

	property p_hihi_all;
		hh_conf[1] |=> spray_q && phb_q && vent_q[1] && msiv_q;
	endproperty
	a_hihi_all: assert property (p_hihi_all) else $error("high-high actuation missing");

	property p_spray_cause;
		$rose(spray_q) |-> $past(|hh_conf || man_spray_s);
	endproperty
	a_spray_cause: assert property (p_spray_cause) else $error("spray without cause");

	property p_man_trip;
		man_si_s[1] |=> si_q[1] && rtrip_q;
	endproperty
	a_man_trip: assert property (p_man_trip) else $error("manual injection ignored");

	property p_defeat_ind;
		si_dft_s[0] |=> lamp_q[0] && alarm_q;
	endproperty
	a_defeat_ind: assert property (p_defeat_ind) else $error("defeat not indicated");

	property p_si_fall;
		$fell(si_q[0]) |-> $past(si_rst_s[0] && (!si_auto[0] || si_dft_s[0]));
	endproperty
	a_si_fall: assert property (p_si_fall) else $error("injection cleared illegally");

	property p_pha_hold;
		pha_q && pha_auto |=> pha_q;
	endproperty
	a_pha_hold: assert property (p_pha_hold) else $error("phase A reset under cause");

	property p_msiv_fall;
		$fell(msiv_q) |-> $past(msiv_rst_s && !msiv_auto);
	endproperty
	a_msiv_fall: assert property (p_msiv_fall) else $error("steam isolation dropped");

	c_spray: cover property ($rose(spray_q));
	c_delay: cover property (dly_st_q == sav_pkg::SAV_TIMING ##1 fire);
	c_defeat: cover property ($fell(si_q[0]) && si_auto[0]);
endmodule

//--- bench/sav_relay_model.sv
// behavioural actuation relays that pick up after a short coil dwell
`timescale 1ns/100ps
module sav_relay_model #(
	parameter int PICK = 2
) (
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [7:0] coil,
	output logic      [7:0] picked
);
	int dwell [8];

	// ------------------------------------------------
	// pick-up timing
	// ------------------------------------------------
	// a relay needs PICK energised cycles to pick; drop-out is immediate,
	// which hides contact bounce but keeps the bench deterministic
	always_ff @(posedge sys_clk or posedge rst) begin
		for (int i = 0; i < 8; i++) begin
			if (rst) begin
				dwell[i] <= 0;
				picked[i] <= 1'b0;
			end else if (!coil[i]) begin
				dwell[i] <= 0;
				picked[i] <= 1'b0;
			end else begin
				dwell[i] <= (dwell[i] < PICK) ? dwell[i] + 1 : dwell[i];
				picked[i] <= (dwell[i] >= PICK - 1);
			end
		end
	end
endmodule

//--- bench/sav_top_tb.sv
// self-checking bench for the safeguard voting block against a behavioural model
`timescale 1ns/100ps
module sav_top_tb;
	localparam int FW  = 12;
	localparam int CPM = 4;
	logic            sys_clk, rst, avs_read, avs_write, avs_waitrequest;
	logic [3:0]      avs_address, avg_coolant_temp_low, steam_press_low;
	logic [31:0]     avs_writedata, avs_readdata, rd;
	logic [4*FW-1:0] flow_a, flow_b;
	logic [FW-1:0]   flow_ref_a, flow_ref_b;
	logic [2:0]      cont_hi_trip;
	logic [11:0]     cont_hihi_trip, outs, m_exp;
	logic [1:0]      man_si, si_reset, si_defeat, vent_reset, si_out, vent_iso, defeat_lamp;
	logic [1:0]      m_si, m_blk, m_vent;
	logic            avg_coolant_temp_perm, steam_press_perm, man_pha, man_phb, man_spray;
	logic            pha_reset, phb_reset, spray_reset, msiv_reset, pha_bypass, vent_b_bypass;
	logic            reactor_trip, msiv_close, spray_out, pha_out, phb_out, control_room_alarm;
	logic            m_msiv, m_spray, m_pha, m_phb, m_brk, m_ilk;
	logic [7:0]      picked;
	int              fails, checks_done, seed;

	// ------------------------------------------------
	// design, relays and clock
	// ------------------------------------------------
	sav_top #(.FW(FW), .CYC_PER_MS(CPM)) sav_top_i (
		.sys_clk, .rst, .avs_address, .avs_read, .avs_write, .avs_writedata,
		.avs_readdata, .avs_waitrequest, .flow_a, .flow_b, .flow_ref_a, .flow_ref_b,
		.avg_coolant_temp_low, .steam_press_low, .avg_coolant_temp_perm,
		.steam_press_perm, .cont_hi_trip, .cont_hihi_trip, .man_si, .si_reset,
		.si_defeat, .man_pha, .man_phb, .man_spray, .pha_reset, .phb_reset,
		.spray_reset, .msiv_reset, .vent_reset, .pha_bypass, .vent_b_bypass, .si_out,
		.reactor_trip, .msiv_close, .spray_out, .pha_out, .phb_out, .vent_iso,
		.defeat_lamp, .control_room_alarm);
	sav_relay_model sav_relay_model_i (.sys_clk, .rst, .picked,
		.coil({vent_iso, phb_out, pha_out, spray_out, msiv_close, si_out}));
	// all actuation outputs in one word for comparison
	assign outs = {si_out, reactor_trip, msiv_close, spray_out, pha_out, phb_out, vent_iso,
		defeat_lamp, control_room_alarm};
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end

	// ------------------------------------------------
	// checking and bus helpers
	// ------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tend(input string s);
		$display("end of %s, checks %0d", s, checks_done);
	endtask
	// entered just after an edge; one idle edge at the end keeps requests apart
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d,
		output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		do begin
			@(posedge sys_clk);
			n++;
		end while (avs_waitrequest !== 1'b0 && n < 100);
		q = avs_readdata;
		if (n >= 100) fails++;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
	endtask
	function automatic int c4(input logic [3:0] v);
		return int'(v[0]) + int'(v[1]) + int'(v[2]) + int'(v[3]);
	endfunction

	// ------------------------------------------------
	// behavioural model, evaluated on settled inputs
	// ------------------------------------------------
	task automatic mdl();
		logic [3:0] hf;
		logic       ha, hb;
		logic [1:0] cz;
		for (int i = 0; i < 4; i++) begin
			hf[i] = (flow_a[i*FW+:FW] > flow_ref_a) || (flow_b[i*FW+:FW] > flow_ref_b);
		end
		m_brk = c4(hf) >= 2;
		m_ilk = m_brk && (c4(avg_coolant_temp_low) >= 2 || c4(steam_press_low) >= 2)
			&& !(avg_coolant_temp_perm && steam_press_perm);
		ha = c4({1'b0, cont_hihi_trip[2:0]}) >= 2 && c4({1'b0, cont_hihi_trip[5:3]}) >= 2;
		hb = c4({1'b0, cont_hihi_trip[8:6]}) >= 2 && c4({1'b0, cont_hihi_trip[11:9]}) >= 2;
		// high-high only reaches its own train's injection
		cz = {2{m_ilk || c4({1'b0, cont_hi_trip}) >= 2}} | {hb, ha};
		for (int t = 0; t < 2; t++) begin
			if (!cz[t] || !si_defeat[t]) m_blk[t] = 1'b0;
			else if (si_reset[t]) m_blk[t] = 1'b1;
			if (man_si[t] || (cz[t] && !m_blk[t])) m_si[t] = 1'b1;
			else if (si_reset[t] && (!cz[t] || si_defeat[t])) m_si[t] = 1'b0;
		end
		if (m_ilk || ha || hb) m_msiv = 1'b1;
		else if (msiv_reset) m_msiv = 1'b0;
		if (ha || hb || man_spray) m_spray = 1'b1;
		else if (spray_reset) m_spray = 1'b0;
		if (ha || hb || man_phb) m_phb = 1'b1;
		else if (phb_reset) m_phb = 1'b0;
		if (|cz || man_pha) m_pha = 1'b1;
		else if (pha_reset || pha_bypass) m_pha = 1'b0;
		if (ha) m_vent[0] = 1'b1;
		else if (vent_reset[0]) m_vent[0] = 1'b0;
		if (hb) m_vent[1] = 1'b1;
		else if (vent_reset[1] || vent_b_bypass) m_vent[1] = 1'b0;
		m_exp = {m_si, |man_si, m_msiv, m_spray, m_pha, m_phb, m_vent, si_defeat, |si_defeat};
	endtask
	// settle, then compare pins, relays and status word with the model
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		mdl();
		chk(outs, m_exp);
		chk(picked, {m_vent, m_phb, m_pha, m_spray, m_msiv, m_si});
		bus(1'b0, 4'h4, 32'h0000_0000, rd);
		chk(rd, {20'h0_0000, m_ilk, m_brk, m_exp[0], m_exp[9], m_vent, m_phb, m_pha,
			m_spray, m_msiv, m_si});
	endtask
	task automatic final_report();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ------------------------------------------------
	// watchdog, far longer than the whole sequence
	// ------------------------------------------------
	initial begin
		repeat (8000) @(posedge sys_clk);
		fails++;
		final_report();
	end

	// ------------------------------------------------
	// main sequence
	// ------------------------------------------------
	initial begin
		seed = 82;
		fails = 0;
		checks_done = 0;
		rst = 1'b1;
		{man_si, si_reset, si_defeat, man_pha, man_phb, man_spray, pha_reset, phb_reset} = '0;
		{spray_reset, msiv_reset, vent_reset, pha_bypass, vent_b_bypass, cont_hi_trip} = '0;
		{avg_coolant_temp_low, steam_press_low, avg_coolant_temp_perm, steam_press_perm} = '0;
		{cont_hihi_trip, flow_a, flow_b, flow_ref_a, flow_ref_b} = '0;
		{avs_read, avs_write, avs_address, avs_writedata} = '0;
		{m_si, m_blk, m_vent, m_msiv, m_spray, m_pha, m_phb, m_brk} = '0;
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		chk({avs_waitrequest, outs}, 32'h0000_1000);
		bus(1'b0, 4'h0, 32'h0000_0000, rd);
		chk(rd, 32'h0000_07d0);
		bus(1'b1, 4'h0, 32'h0000_0bb8, rd);
		bus(1'b0, 4'h0, 32'h0000_0000, rd);
		chk(rd, 32'h0000_07d0);
		bus(1'b1, 4'h8, 32'hffff_ffff, rd);
		bus(1'b0, 4'h8, 32'h0000_0000, rd);
		chk(rd, 32'h0000_0000);
		bus(1'b1, 4'h4, 32'hffff_ffff, rd);
		bus(1'b1, 4'h0, 32'h0000_0000, rd);
		tend("registers");
		// random flows with no low vote: break word only, nothing latches
		for (int i = 0; i < 8; i++) begin
			flow_a <= {16'($random(seed)), 32'($random(seed))};
			flow_b <= {16'($random(seed)), 32'($random(seed))};
			flow_ref_a <= 12'($random(seed));
			flow_ref_b <= 12'($random(seed));
			step(8);
		end
		tend("flow vote");
		flow_a <= 48'h0000_00ff_ffff;
		flow_b <= 48'h0000_0000_0000;
		flow_ref_a <= 12'h100;
		flow_ref_b <= 12'hfff;
		avg_coolant_temp_low <= 4'h3;
		{avg_coolant_temp_perm, steam_press_perm} <= 2'b11;
		step(12);
		tend("permissive");
		bus(1'b1, 4'h0, 32'h0000_0003, rd);
		avg_coolant_temp_low <= 4'h0;
		steam_press_low <= 4'h5;
		steam_press_perm <= 1'b0;
		repeat (10) @(posedge sys_clk);
		chk(msiv_close, 1'b0);
		step(40);
		flow_a <= '0;
		steam_press_low <= 4'h0;
		bus(1'b1, 4'h0, 32'h0000_0000, rd);
		step(10);
		{msiv_reset, pha_reset, si_reset} <= 4'hf;
		step(8);
		{msiv_reset, pha_reset, si_reset} <= 4'h0;
		step(4);
		// same break with a zero delay: fire and actuation follow within a few edges
		flow_a <= 48'h0000_00ff_ffff;
		steam_press_low <= 4'h5;
		step(8);
		flow_a <= '0;
		steam_press_low <= 4'h0;
		{msiv_reset, pha_reset, si_reset} <= 4'hf;
		step(8);
		{msiv_reset, pha_reset, si_reset} <= 4'h0;
		step(4);
		tend("steam break");
		cont_hi_trip <= 3'b101;
		step(10);
		si_reset <= 2'b11;
		step(8);
		si_defeat <= 2'b01;
		step(8);
		man_si <= 2'b01;
		step(8);
		{man_si, si_reset, si_defeat, cont_hi_trip} <= '0;
		step(6);
		{si_reset, pha_bypass} <= 3'b111;
		step(8);
		{si_reset, pha_bypass} <= 3'b000;
		man_si <= 2'b10;
		step(8);
		man_si <= 2'b00;
		si_reset <= 2'b11;
		step(8);
		si_reset <= 2'b00;
		tend("injection");
		cont_hihi_trip <= 12'h003;
		step(10);
		// train A confirmed alone: train B injection and ventilation stay off
		cont_hihi_trip <= 12'h03f;
		step(10);
		cont_hihi_trip <= 12'hfff;
		step(10);
		{spray_reset, phb_reset, pha_reset, msiv_reset, vent_reset, si_reset} <= 8'hf7;
		vent_b_bypass <= 1'b1;
		step(8);
		cont_hihi_trip <= '0;
		step(8);
		{spray_reset, phb_reset, pha_reset, msiv_reset, vent_reset, si_reset} <= 8'h00;
		vent_b_bypass <= 1'b0;
		step(4);
		tend("high-high");
		{man_spray, man_phb, man_pha} <= 3'b111;
		{spray_reset, phb_reset, pha_reset} <= 3'b111;
		step(8);
		{man_spray, man_phb, man_pha} <= 3'b000;
		step(8);
		{spray_reset, phb_reset, pha_reset} <= 3'b000;
		step(4);
		tend("manual");
		final_report();
	end
endmodule
